// File: dtc_pkg.sv
// Purpose: Shared constants for the dual 8-bit interval timer pair
// Assumes: Byte-wide registers on a 32-bit Wishbone word grid
// Notes:   All offsets are byte addresses on the low address byte

package dtc_pkg;

    ////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] OFS_POWER      = 8'h00;
    localparam logic [7:0] OFS_PAIR       = 8'h04;
    localparam logic [7:0] OFS_MODE [2]   = '{8'h08, 8'h0c};
    localparam logic [7:0] OFS_CMP  [2]   = '{8'h10, 8'h14};
    localparam logic [7:0] OFS_CNT  [2]   = '{8'h18, 8'h1c};

    ////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int GATE_BIT      = 4;
    localparam int RUN_LO_BIT    = 0;
    localparam int RUN_HI_BIT    = 1;
    localparam int CASCADE_BIT   = 2;
    localparam int OUTAND_BIT    = 3;
    localparam int MODE_DBE_BIT  = 7;
    localparam int MODE_OP_LSB   = 4;
    localparam int MODE_EXT_BIT  = 3;
    localparam int MODE_CLK_LSB  = 0;

    ////////////////////////////////////////////////////////////////////
    // Values after reset and masks
    localparam logic [7:0] POWER_RST     = 8'h00;
    localparam logic [7:0] PAIR_RST      = 8'h00;
    localparam logic [7:0] MODE_RST      = 8'h00;
    localparam logic [7:0] CMP_RST       = 8'h00;
    localparam logic [7:0] COUNT_CLEAR   = 8'h00;
    localparam logic [7:0] PAIR_RW_MASK  = 8'h0f;

    ////////////////////////////////////////////////////////////////////
    // Prescaler layout
    localparam int DIV_W    = 11;
    localparam int LF_DIV_W = 4;
    localparam logic [DIV_W-1:0] GEAR_MASK [8] = '{
        11'h7ff, 11'h3ff, 11'h0ff, 11'h03f,
        11'h00f, 11'h003, 11'h001, 11'h000};
    localparam logic [2:0] CODE_LF16 = 3'h0;
    localparam logic [2:0] CODE_LF8  = 3'h1;
    localparam logic [2:0] CODE_LF4  = 3'h7;
    localparam int SYNC_PINS = 3;

endpackage : dtc_pkg

// File: dtc_chan.sv
// Purpose: One 8-bit interval counter with compare and staging buffer
// Assumes: tick_i is a one-cycle enable in the basic clock domain
// Notes:   Compare value zero gives a 256-tick interval

`timescale 1ns/1ps

module dtc_chan
    import dtc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Control
    input  wire logic       run_i,
    input  wire logic       tick_i,
    input  wire logic       dbe_i,
    input  wire logic       cmp_wr_i,
    input  wire logic [7:0] cmp_data_i,
    // State
    output logic      [7:0] count_o,
    output logic      [7:0] cmp_buf_o,
    output logic            match_o
);

    logic [7:0] cnt_reg;
    logic [7:0] cmp_reg;
    logic [7:0] buf_reg;
    logic       match_reg;
    logic [7:0] cnt_inc;
    logic       hit;

    assign cnt_inc = cnt_reg + 8'h01;
    // Interval equals compare value times tick period
    assign hit     = run_i & tick_i & (cnt_inc == cmp_reg);

    ////////////////////////////////////////////////////////////////////
    // Counter
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_reg <= COUNT_CLEAR;
        else if (!run_i)
            cnt_reg <= COUNT_CLEAR;
        else if (hit)
            cnt_reg <= COUNT_CLEAR;
        else if (tick_i)
            cnt_reg <= cnt_inc;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            match_reg <= 1'b0;
        else
            match_reg <= hit;
    end

    ////////////////////////////////////////////////////////////////////
    // Compare and staging buffer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            buf_reg <= CMP_RST;
        else if (cmp_wr_i)
            buf_reg <= cmp_data_i;
    end

    // Old buffer wins over a write landing on the match cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cmp_reg <= CMP_RST;
        else if (cmp_wr_i && (!dbe_i || !run_i))
            cmp_reg <= cmp_data_i;
        else if (hit && dbe_i)
            cmp_reg <= buf_reg;
    end

    assign count_o   = cnt_reg;
    assign cmp_buf_o = buf_reg;
    assign match_o   = match_reg;

    ////////////////////////////////////////////////////////////////////
    // Checks
    AST_MATCH_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        match_reg |-> (cnt_reg == 8'h00))
        else $error("counter not cleared on match");

    AST_STOP_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        !run_i |=> (cnt_reg == 8'h00))
        else $error("stopped counter not cleared");

    AST_TICK_INC: assert property (@(posedge clk_i) disable iff (rst_i)
        (run_i && tick_i && !hit) |=> (cnt_reg == 8'($past(cnt_reg) + 8'h01)))
        else $error("counter did not advance on tick");

    AST_DBUF_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (dbe_i && run_i && cmp_wr_i && !hit) |=> $stable(cmp_reg))
        else $error("staged write reached compare early");

    AST_READBACK: assert property (@(posedge clk_i) disable iff (rst_i)
        cmp_wr_i |=> (buf_reg == $past(cmp_data_i)))
        else $error("compare readback differs from write");

    AST_DIRECT_WR: assert property (@(posedge clk_i) disable iff (rst_i)
        (cmp_wr_i && !dbe_i) |=> (cmp_reg == $past(cmp_data_i)))
        else $error("direct compare write not applied");

endmodule : dtc_chan

// File: dtc_top.sv
// Purpose: Dual 8-bit timer pair with clock gate, prescalers and bus
// Assumes: CLK_I is the gear clock, 50 MHz; LF_CLK_I is asynchronous
// Notes:   16-bit, PWM and PPG modes select clocks only
//
// What this block does
// - Fast codes pick gear divisions or low-frequency substitutes
// - Slow mode: codes 000, 001, 111 only
// - Cascade takes clock from high timer selection
// - Dead low-frequency clock delivers no ticks
// - Clock gate zero freezes both counters
// - Clock gate resets to zero
// - Independent and cascaded mode codes are held
// - Interval mode uses internal selected source clock
// - Eight-bit compare value matched against counter
// - Double buffer enable stages compare writes
// - Mode writes ignored while that timer runs
// - Counter increments once per source tick
// - Match pulses flag, clears counter, continues
// - Run cleared stops and zeroes counter
// - High timer mirrors low timer behaviour
// - Staged value loads at match; stopped writes direct
// - Unbuffered write applies at once, may wrap
// - Compare reads return last written value

`timescale 1ns/1ps

module dtc_top
    import dtc_pkg::*;
(
    // Wishbone slave
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    // Clock sources and system mode
    input  wire logic        LF_CLK_I,
    input  wire logic        LF_OSC_OK_I,
    input  wire logic        SLOW_MODE_I,
    input  wire logic        LF_SUBST_I,
    // Event pins
    input  wire logic        EVENT_LOW_I,
    input  wire logic        EVENT_HIGH_I,
    // Match pulses
    output logic             LOW_MATCH_IRQ_O,
    output logic             HIGH_MATCH_IRQ_O
);

    logic             ack_reg;
    logic [31:0]      dat_reg;
    logic [7:0]       power_gate_reg;
    logic [7:0]       pair_control_reg;
    logic [7:0]       pair_control_next;
    logic [7:0]       mode_reg [2];
    logic [7:0]       rd_byte;
    logic             req;
    logic             wr;
    logic [7:0]       wdat;
    logic             gate;
    logic             cas;
    logic             lock;
    logic [1:0]       run;
    logic [1:0]       tick;
    logic [1:0]       match;
    logic [7:0]       count   [2];
    logic [7:0]       cmp_buf [2];
    logic [SYNC_PINS-1:0] pin_rise;
    logic [SYNC_PINS-1:0] pin_fall;
    logic [DIV_W-1:0]     div_reg;
    logic [LF_DIV_W-1:0]  lf_div_reg;
    logic [7:0]       gear_tap;
    logic             lf_edge;
    logic             lf_tap16;
    logic             lf_tap8;
    logic             lf_tap4;

    ////////////////////////////////////////////////////////////////////
    // Bus slave: one wait state, byte lane 0 only
    assign req  = CYC_I & STB_I & ~ack_reg;
    assign wr   = req & WE_I & SEL_I[0];
    assign wdat = DAT_I[7:0];

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            ack_reg <= 1'b0;
        else
            ack_reg <= req;
    end

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            dat_reg <= 32'h0;
        else if (req && !WE_I)
            dat_reg <= {24'h0, rd_byte};
    end

    always_comb
    begin
        case (ADR_I)
            OFS_POWER:   rd_byte = power_gate_reg;
            OFS_PAIR:    rd_byte = pair_control_reg & PAIR_RW_MASK;
            OFS_MODE[0]: rd_byte = mode_reg[0];
            OFS_MODE[1]: rd_byte = mode_reg[1];
            OFS_CMP[0]:  rd_byte = cmp_buf[0];
            OFS_CMP[1]:  rd_byte = cmp_buf[1];
            OFS_CNT[0]:  rd_byte = count[0];
            OFS_CNT[1]:  rd_byte = count[1];
            default:     rd_byte = 8'h00;
        endcase
    end

    assign DAT_O = dat_reg;
    assign ACK_O = ack_reg;

    ////////////////////////////////////////////////////////////////////
    // Power gate and pair control
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            power_gate_reg <= POWER_RST;
        else if (wr && ADR_I == OFS_POWER)
            power_gate_reg <= wdat;
    end

    assign gate = power_gate_reg[GATE_BIT];
    assign cas  = pair_control_reg[CASCADE_BIT];
    assign run  = {pair_control_reg[RUN_HI_BIT], pair_control_reg[RUN_LO_BIT]};
    assign lock = |run;

    // Cascade and output combine bits freeze while either timer runs
    always_comb
    begin
        pair_control_next = wdat & PAIR_RW_MASK;
        if (lock)
        begin
            pair_control_next[CASCADE_BIT] = pair_control_reg[CASCADE_BIT];
            pair_control_next[OUTAND_BIT]  = pair_control_reg[OUTAND_BIT];
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            pair_control_reg <= PAIR_RST;
        else if (wr && ADR_I == OFS_PAIR)
            pair_control_reg <= pair_control_next;
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers: low-frequency clock and two event pins
    generate
        for (genvar p = 0; p < SYNC_PINS; p++)
        begin : g_sync
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic lvl_reg;
            logic pin;

            assign pin = (p == 0) ? LF_CLK_I : ((p == 1) ? EVENT_LOW_I : EVENT_HIGH_I);

            always_ff @(posedge CLK_I)
            begin
                if (RST_I)
                begin
                    s1_reg  <= 1'b0;
                    s2_reg  <= 1'b0;
                    s3_reg  <= 1'b0;
                    lvl_reg <= 1'b0;
                end
                else
                begin
                    s1_reg <= pin;
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg)
                        lvl_reg <= s3_reg;
                end
            end

            assign pin_rise[p] = (s2_reg == s3_reg) & s3_reg & ~lvl_reg;
            assign pin_fall[p] = (s2_reg == s3_reg) & ~s3_reg & lvl_reg;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Prescalers as enable pulses, never as derived clocks
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            div_reg <= '0;
        else if (gate)
            div_reg <= div_reg + 11'h001;
    end

    generate
        for (genvar k = 0; k < 8; k++)
        begin : g_gear
            assign gear_tap[k] = gate & ((div_reg & GEAR_MASK[k]) == GEAR_MASK[k]);
        end
    endgenerate

    // No edges arrive from a stopped oscillator
    assign lf_edge = pin_rise[0] & LF_OSC_OK_I & gate;

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            lf_div_reg <= '0;
        else if (lf_edge)
            lf_div_reg <= lf_div_reg + 4'h1;
    end

    assign lf_tap16 = lf_edge & (lf_div_reg == 4'hf);
    assign lf_tap8  = lf_edge & (lf_div_reg[2:0] == 3'h7);
    assign lf_tap4  = lf_edge & (lf_div_reg[1:0] == 2'h3);

    ////////////////////////////////////////////////////////////////////
    // Per-timer mode register, source select and counter
    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_chan
            logic [2:0] code;
            logic       ext;
            logic       ev;
            logic       int_tick;

            always_ff @(posedge CLK_I)
            begin
                if (RST_I)
                    mode_reg[i] <= MODE_RST;
                else if (wr && ADR_I == OFS_MODE[i] && !run[i])
                    mode_reg[i] <= wdat;
            end

            // Cascade reads the high timer selection for both halves
            assign code = cas ? mode_reg[1][MODE_CLK_LSB+:3]
                              : mode_reg[i][MODE_CLK_LSB+:3];
            assign ext  = cas ? mode_reg[1][MODE_EXT_BIT]
                              : mode_reg[i][MODE_EXT_BIT];
            assign ev   = cas ? pin_fall[1] : pin_fall[1+i];

            always_comb
            begin
                int_tick = 1'b0;
                if (SLOW_MODE_I)
                begin
                    case (code)
                        CODE_LF16: int_tick = lf_tap16;
                        CODE_LF8:  int_tick = lf_tap8;
                        CODE_LF4:  int_tick = lf_tap4;
                        default:   int_tick = 1'b0;
                    endcase
                end
                else if (LF_SUBST_I && code == CODE_LF16)
                    int_tick = lf_tap16;
                else if (LF_SUBST_I && code == CODE_LF8)
                    int_tick = lf_tap8;
                else
                    int_tick = gear_tap[code];
            end

            // Event modes count only falling edges on the pin
            assign tick[i] = ext ? (ev & gate) : int_tick;

            dtc_chan u_chan (
                .clk_i      (CLK_I),
                .rst_i      (RST_I),
                .run_i      (run[i]),
                .tick_i     (tick[i]),
                .dbe_i      (mode_reg[i][MODE_DBE_BIT]),
                .cmp_wr_i   (wr && ADR_I == OFS_CMP[i]),
                .cmp_data_i (wdat),
                .count_o    (count[i]),
                .cmp_buf_o  (cmp_buf[i]),
                .match_o    (match[i])
            );
        end
    endgenerate

    assign LOW_MATCH_IRQ_O  = match[0];
    assign HIGH_MATCH_IRQ_O = match[1];

    ////////////////////////////////////////////////////////////////////
    // Checks
    AST_GATE_RESET: assert property (@(posedge CLK_I)
        RST_I |=> !power_gate_reg[GATE_BIT])
        else $error("clock gate not cleared by reset");

    AST_GATE_BLOCKS: assert property (@(posedge CLK_I) disable iff (RST_I)
        !gate |-> (tick == 2'b00))
        else $error("tick while clock gate is off");

    AST_FAST_CODE: assert property (@(posedge CLK_I) disable iff (RST_I)
        (!SLOW_MODE_I && gate && !cas && mode_reg[0][3:0] == 4'h7) |-> tick[0])
        else $error("undivided code gave no tick");

    AST_SLOW_CODES: assert property (@(posedge CLK_I) disable iff (RST_I)
        (SLOW_MODE_I && !cas && !mode_reg[0][MODE_EXT_BIT]
         && mode_reg[0][2:0] inside {[3'h2:3'h6]}) |-> !tick[0])
        else $error("unusable slow code produced a tick");

    AST_CASCADE_SRC: assert property (@(posedge CLK_I) disable iff (RST_I)
        cas |-> (tick[0] == tick[1]))
        else $error("cascade halves on different sources");

    AST_LF_DEAD: assert property (@(posedge CLK_I) disable iff (RST_I)
        !LF_OSC_OK_I |-> !lf_edge)
        else $error("low-frequency edge without oscillator");

    AST_MODE_LOCK: assert property (@(posedge CLK_I) disable iff (RST_I)
        (run[0] && wr && ADR_I == OFS_MODE[0]) |=> $stable(mode_reg[0]))
        else $error("mode written while running");

    AST_BUS_ACK: assert property (@(posedge CLK_I) disable iff (RST_I)
        (CYC_I && STB_I && !ack_reg) |=> ack_reg ##1 !ack_reg)
        else $error("ack not a single cycle after request");

endmodule : dtc_top

// File: test_dtc_top.sv
// Purpose: Self-checking bench for the dual 8-bit interval timer pair
// Assumes: Wishbone classic master; low-freq pin made here at 1/10 of CLK_I
// Notes:   Intervals are counted between two match pulses, so prescaler phase drops out

`timescale 1ns/1ps

module test_dtc_top;
    import dtc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Stimulus and observed signals
    logic        CLK_I, RST_I, CYC_I, STB_I, WE_I;
    logic [7:0]  ADR_I;
    logic [3:0]  SEL_I;
    logic [31:0] DAT_I, DAT_O;
    logic        ACK_O, LF_CLK_I, LF_OSC_OK_I, SLOW_MODE_I, LF_SUBST_I;
    logic        EVENT_LOW_I, EVENT_HIGH_I, LOW_MATCH_IRQ_O, HIGH_MATCH_IRQ_O;
    int          err_total, checked, lf_cnt, lo_hits, n, h;
    logic [31:0] d;
    int          gear_div [8] = '{2048, 1024, 256, 64, 16, 4, 2, 1};
    logic [7:0]  reg_ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};

    dtc_top dut (.CLK_I(CLK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
        .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
        .LF_CLK_I(LF_CLK_I), .LF_OSC_OK_I(LF_OSC_OK_I), .SLOW_MODE_I(SLOW_MODE_I),
        .LF_SUBST_I(LF_SUBST_I), .EVENT_LOW_I(EVENT_LOW_I), .EVENT_HIGH_I(EVENT_HIGH_I),
        .LOW_MATCH_IRQ_O(LOW_MATCH_IRQ_O), .HIGH_MATCH_IRQ_O(HIGH_MATCH_IRQ_O));

    always #10 CLK_I = ~CLK_I;

    // Low-freq source stands still while the oscillator is reported dead
    always @(posedge CLK_I)
    begin
        if (LF_OSC_OK_I)
        begin
            lf_cnt <= (lf_cnt == 4) ? 0 : lf_cnt + 1;
            if (lf_cnt == 4)
                LF_CLK_I <= ~LF_CLK_I;
        end
    end

    always @(posedge CLK_I)
    begin
        if (LOW_MATCH_IRQ_O === 1'b1)
            lo_hits <= lo_hits + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus and check tasks
    task automatic test_done();
        if (err_total == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask : chk

    // Values seen right at the edge are the ones that edge samples
    task automatic wb_cycle(input logic [7:0] a, input logic w, input logic [7:0] wd,
                            output logic [31:0] rd);
        int k;
        @(posedge CLK_I);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I  <= w;
        ADR_I <= a;
        DAT_I <= {24'h0, wd};
        k = 0;
        do
        begin
            @(posedge CLK_I);
            k++;
        end while (ACK_O !== 1'b1 && k < 100);
        if (k >= 100)
            err_total++;
        rd = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        WE_I  <= 1'b0;
    endtask : wb_cycle

    task automatic wb_write(input logic [7:0] a, input logic [7:0] wd);
        logic [31:0] r;
        wb_cycle(a, 1'b1, wd, r);
    endtask : wb_write

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        wb_cycle(a, 1'b0, 8'h00, r);
        chk(r, exp);
    endtask : rd_chk

    // Cycles until the next match pulse of the chosen timer
    task automatic wait_m(input logic hi, output int c);
        c = 0;
        do
        begin
            @(posedge CLK_I);
            c++;
        end while ((hi ? HIGH_MATCH_IRQ_O : LOW_MATCH_IRQ_O) !== 1'b1 && c < 20000);
    endtask : wait_m

    task automatic measure(input logic hi, output int c);
        wait_m(hi, c);
        wait_m(hi, c);
    endtask : measure

    task automatic run_cfg(input int t, input logic [7:0] mode, input logic [7:0] cmp);
        wb_write(OFS_PAIR, 8'h00);
        wb_write(OFS_MODE[t], mode);
        wb_write(OFS_CMP[t], cmp);
        wb_write(OFS_PAIR, (t == 1) ? 8'h02 : 8'h01);
    endtask : run_cfg

    ////////////////////////////////////////////////////////////////////////
    // Watchdog, sized well above the longest gear interval sweep
    initial
    begin
        repeat (80000) @(posedge CLK_I);
        err_total++;
        test_done();
    end

    initial
    begin
        {CLK_I, CYC_I, STB_I, WE_I, ADR_I, DAT_I, LF_CLK_I} = '0;
        {SLOW_MODE_I, LF_SUBST_I, EVENT_LOW_I, EVENT_HIGH_I} = '0;
        {err_total, checked, lf_cnt, lo_hits} = '0;
        SEL_I = 4'hf;
        LF_OSC_OK_I = 1'b1;
        RST_I = 1'b1;
        repeat (8) @(posedge CLK_I);
        RST_I <= 1'b0;
        foreach (reg_ofs[i])
            rd_chk(reg_ofs[i], 32'h0);
        wb_write(8'h40, 8'hff);
        rd_chk(8'h40, 32'h0);
        wb_write(OFS_POWER, 8'h10);
        rd_chk(OFS_POWER, 32'h10);
        // Gate dropped only while stopped, so the freeze is legal to probe
        wb_write(OFS_MODE[0], 8'h07);
        wb_write(OFS_CMP[0], 8'h05);
        wb_write(OFS_POWER, 8'h00);
        wb_write(OFS_PAIR, 8'h01);
        repeat (50) @(posedge CLK_I);
        rd_chk(OFS_CNT[0], 32'h0);
        wb_write(OFS_POWER, 8'h10);
        measure(1'b0, n);
        chk(32'(n), 32'd5);
        wb_write(OFS_MODE[0], 8'h06);
        rd_chk(OFS_MODE[0], 32'h07);
        wb_write(OFS_CMP[0], 8'hc8);
        repeat (40) @(posedge CLK_I);
        wb_cycle(OFS_CNT[0], 1'b0, 8'h00, d);
        chk({31'h0, d[7:0] > 8'h10}, 32'h1);
        wb_write(OFS_PAIR, 8'h00);
        rd_chk(OFS_CNT[0], 32'h0);
        // Every gear division, compare 2
        for (int k = 0; k < 8; k++)
        begin
            run_cfg(0, 8'(k), 8'h02);
            measure(1'b0, n);
            chk(32'(n), 32'(2 * gear_div[k]));
        end
        // Low-freq substitutes: one lf period is 10 cycles
        LF_SUBST_I <= 1'b1;
        run_cfg(0, 8'h00, 8'h02);
        measure(1'b0, n);
        chk(32'(n), 32'd320);
        run_cfg(0, 8'h01, 8'h02);
        measure(1'b0, n);
        chk(32'(n), 32'd160);
        SLOW_MODE_I <= 1'b1;
        run_cfg(0, 8'h07, 8'h02);
        measure(1'b0, n);
        chk(32'(n), 32'd80);
        run_cfg(0, 8'h00, 8'h02);
        measure(1'b0, n);
        chk(32'(n), 32'd320);
        // Gear-only code in slow mode must stay silent
        run_cfg(0, 8'h02, 8'h02);
        h = lo_hits;
        repeat (200) @(posedge CLK_I);
        chk(32'(lo_hits - h), 32'd0);
        rd_chk(OFS_CNT[0], 32'h0);
        LF_OSC_OK_I <= 1'b0;
        run_cfg(0, 8'h07, 8'h02);
        h = lo_hits;
        repeat (400) @(posedge CLK_I);
        chk(32'(lo_hits - h), 32'd0);
        rd_chk(OFS_CNT[0], 32'h0);
        {LF_OSC_OK_I, SLOW_MODE_I, LF_SUBST_I} <= 3'b100;
        // Staged compare: old value serves until the next match
        run_cfg(0, 8'h87, 8'h04);
        measure(1'b0, n);
        chk(32'(n), 32'd4);
        // Readback waits: a bus cycle here would hide the old-value match
        wb_write(OFS_CMP[0], 8'h08);
        wait_m(1'b0, n);
        chk({31'h0, n <= 4}, 32'h1);
        wait_m(1'b0, n);
        chk(32'(n), 32'd8);
        rd_chk(OFS_CMP[0], 32'h08);
        run_cfg(0, 8'h87, 8'h03);
        measure(1'b0, n);
        chk(32'(n), 32'd3);
        // Unbuffered write below the count must wait for a wrap
        run_cfg(0, 8'h07, 8'hc8);
        wait_m(1'b0, n);
        repeat (100) @(posedge CLK_I);
        wb_write(OFS_CMP[0], 8'h32);
        wait_m(1'b0, n);
        chk({31'h0, n > 100}, 32'h1);
        wait_m(1'b0, n);
        chk(32'(n), 32'd50);
        run_cfg(1, 8'h07, 8'h03);
        measure(1'b1, n);
        chk(32'(n), 32'd3);
        // Cascade: low timer must follow the high timer's divide-by-2
        wb_write(OFS_PAIR, 8'h00);
        wb_write(OFS_MODE[0], 8'h07);
        wb_write(OFS_MODE[1], 8'h06);
        wb_write(OFS_CMP[0], 8'h03);
        wb_write(OFS_PAIR, 8'h07);
        measure(1'b0, n);
        chk(32'(n), 32'd6);
        // Pin-driven counting ignores the internal source
        wb_write(OFS_PAIR, 8'h00);
        run_cfg(0, 8'h0f, 8'h03);
        h = lo_hits;
        repeat (50) @(posedge CLK_I);
        rd_chk(OFS_CNT[0], 32'h0);
        repeat (3)
        begin
            EVENT_LOW_I <= 1'b1;
            repeat (4) @(posedge CLK_I);
            EVENT_LOW_I <= 1'b0;
            repeat (4) @(posedge CLK_I);
        end
        repeat (8) @(posedge CLK_I);
        chk(32'(lo_hits - h), 32'd1);
        test_done();
    end

endmodule : test_dtc_top
